// >>> core/buck_regulator_sequencer.sv
`timescale 1ns/1ps
`include "buck_map.svh"
module buck_regulator_sequencer #(
  parameter bit STRAP_TABLE = 1'b0,
  parameter int ED_CYC      = `EN_DELAY_CYC,
  parameter int SS_CYC      = `SOFT_START_CYC,
  parameter int PG_CYC      = `PG_DELAY_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        chip_enable_i,
  input  wire logic        voltage_select_pin_i,
  input  wire logic        voltage_select_first_i,
  input  wire logic        voltage_select_second_i,
  input  wire logic        input_undervoltage_lockout_i,
  input  wire logic        thermal_i,
  input  wire logic        hs_limit_i,
  input  wire logic        ls_limit_i,
  input  wire logic        at_96_i,
  input  wire logic        at_target_i,
  input  wire logic        light_load_save_mode_i,
  input  wire logic        hs_request_i,
  input  wire logic [6:0]  prebias_code_i,
  output logic             hs_on_o,
  output logic             ls_on_o,
  output logic             discharge_o,
  output logic             forced_pwm_o,
  output logic      [6:0]  ref_code_o,
  output logic             power_good_output_o,
  output logic             power_good_output_oe_o
);

  // ==================== Functions
  function automatic logic [6:0] strap_lookup(input logic a, input logic b);
    case ({b, a})
      2'b00:   strap_lookup = `STRAP_00;
      2'b01:   strap_lookup = `STRAP_10;
      2'b10:   strap_lookup = `STRAP_01;
      default: strap_lookup = `STRAP_11;
    endcase
  endfunction : strap_lookup

  function automatic logic [15:0] ramp_interval(input logic [1:0] r);
    case (r)
      2'd0:    ramp_interval = `RAMP_STEP0;
      2'd1:    ramp_interval = `RAMP_STEP1;
      2'd2:    ramp_interval = `RAMP_STEP2;
      default: ramp_interval = `RAMP_STEP3;
    endcase
  endfunction : ramp_interval

  // ==================== Pin synchroniser
  logic [`NPINS-1:0] pin_raw, s1, s2, s3, pf;
  assign pin_raw = {hs_request_i, light_load_save_mode_i, at_target_i, at_96_i,
                    ls_limit_i, hs_limit_i, thermal_i, input_undervoltage_lockout_i,
                    voltage_select_second_i, voltage_select_first_i,
                    voltage_select_pin_i, chip_enable_i};

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      pf <= '0;
    end else begin
      s1 <= pin_raw;
      s2 <= s1;
      s3 <= s2;
      pf <= (s2 & s3) | (pf & (s2 ^ s3));
    end
  end

  logic en, pick, vs1, vs2, input_undervoltage_lockout, tsd, hsl, lsl, a96, atg, pfm, hsr;
  assign en   = pf[`P_EN];
  assign pick = pf[`P_PICK];
  assign vs1  = pf[`P_VS1];
  assign vs2  = pf[`P_VS2];
  assign input_undervoltage_lockout = pf[`P_INPUT_UNDERVOLTAGE_LOCKOUT];
  assign tsd  = pf[`P_TSD];
  assign hsl  = pf[`P_HSL];
  assign lsl  = pf[`P_LSL];
  assign a96  = pf[`P_A96];
  assign atg  = pf[`P_ATG];
  assign pfm  = pf[`P_PFM];
  assign hsr  = pf[`P_HSR];

  logic en_d, ever;
  logic en_rise;
  assign en_rise = en & ~en_d;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      en_d <= 1'b0;
      ever <= 1'b0;
    end else begin
      en_d <= en;
      ever <= ever | en;
    end
  end

  // ==================== Control registers
  logic [6:0] set_one, set_two;
  logic [1:0] ramp;
  logic       fpwm, swen, fchg, disch;
  logic       therm;
  buck_pkg::seq_state_t state, next_state;
  logic [19:0] timer;

  // Thermal sensing is meaningless while in light-load mode
  assign therm = tsd & ~(pfm & ~fpwm);

  // ==================== Sequencer
  always_comb begin
    next_state = state;
    case (state)
      buck_pkg::ST_OFF:
        if (en && !input_undervoltage_lockout) next_state = buck_pkg::ST_DELAY;
      buck_pkg::ST_DELAY:
        if (timer == 20'(ED_CYC - 1))
          next_state = swen ? buck_pkg::ST_SOFT : buck_pkg::ST_IDLE;
      buck_pkg::ST_SOFT:
        if (timer == 20'(SS_CYC - 1)) next_state = buck_pkg::ST_RUN;
      buck_pkg::ST_RUN:
        next_state = buck_pkg::ST_RUN;
      buck_pkg::ST_IDLE:
        if (swen) next_state = buck_pkg::ST_SOFT;
      buck_pkg::ST_THERM:
        if (!tsd) next_state = buck_pkg::ST_SOFT;
      buck_pkg::ST_INPUT_UNDERVOLTAGE_LOCKOUT:
        if (!input_undervoltage_lockout) next_state = buck_pkg::ST_DELAY;
      default:
        next_state = buck_pkg::ST_OFF;
    endcase
    if ((state == buck_pkg::ST_SOFT || state == buck_pkg::ST_RUN) && !swen)
      next_state = buck_pkg::ST_IDLE;
    if ((state == buck_pkg::ST_SOFT || state == buck_pkg::ST_RUN) && therm)
      next_state = buck_pkg::ST_THERM;
    if (input_undervoltage_lockout && state != buck_pkg::ST_OFF)
      next_state = buck_pkg::ST_INPUT_UNDERVOLTAGE_LOCKOUT;
    if (!en)
      next_state = buck_pkg::ST_OFF;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) state <= buck_pkg::ST_OFF;
    else state <= next_state;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i || state != next_state) timer <= '0;
    else if (timer != '1) timer <= timer + 20'd1;
  end

  logic run, live;
  assign run  = (state == buck_pkg::ST_SOFT) || (state == buck_pkg::ST_RUN);
  // Bus is dead while off, during enable delay and in lockout
  assign live = run || state == buck_pkg::ST_IDLE || state == buck_pkg::ST_THERM;

  // ==================== AHB-Lite slave
  logic       wr_pend, take;
  logic [7:0] wr_ofs;
  logic [31:0] rd_mux;
  logic       wr_ok, wr_ctl;
  logic       dynamic_voltage_change, cl, pg_low;
  logic [6:0] strap_code, target, target_d;

  assign take   = hsel_i & htrans_i[1] & hready_i;
  assign wr_ok  = wr_pend & live;
  assign wr_ctl = wr_ok && wr_ofs == `OFS_CTL;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr_i[7:0])
      `OFS_SET_ONE: rd_mux = {25'h0, set_one};
      `OFS_SET_TWO: rd_mux = {25'h0, set_two};
      `OFS_CTL:     rd_mux = {25'h0, fchg, swen, fpwm, disch, 1'b0, ramp};
      `OFS_STATUS:  rd_mux = {12'h000, ref_code_o, target, state, dynamic_voltage_change, cl, pg_low};
      default:      rd_mux = 32'h0000_0000;
    endcase
    if (!live) rd_mux = 32'h0000_0000;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wr_pend     <= 1'b0;
      wr_ofs      <= 8'h00;
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      wr_pend     <= take & hwrite_i;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (take) wr_ofs <= haddr_i[7:0];
      if (take && !hwrite_i) hrdata_o <= rd_mux;
    end
  end

  // EN low wipes all settings except the discharge bit
  always_ff @(posedge clk_i) begin
    if (!resetn_i || !en) begin
      set_one <= `SET_ONE_RST;
      set_two <= `SET_TWO_RST;
      ramp    <= `RAMP_RST;
      fpwm    <= 1'b0;
      swen    <= `SWEN_RST;
      fchg    <= 1'b0;
    end else if (wr_ok) begin
      if (wr_ofs == `OFS_SET_ONE) set_one <= hwdata_i[6:0];
      if (wr_ofs == `OFS_SET_TWO) set_two <= hwdata_i[6:0];
      if (wr_ctl) begin
        ramp <= hwdata_i[`CTL_RAMP_LSB +: 2];
        fpwm <= hwdata_i[`CTL_FPWM];
        swen <= hwdata_i[`CTL_SWEN];
        fchg <= hwdata_i[`CTL_FCHG];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i || en_rise) disch <= `DIS_RST;
    else if (wr_ctl) disch <= hwdata_i[`CTL_DIS];
  end

  // ==================== Target and ramp
  always_ff @(posedge clk_i) begin
    if (!resetn_i) strap_code <= `STRAP_00;
    else if (state == buck_pkg::ST_DELAY) strap_code <= strap_lookup(vs1, vs2);
  end

  assign target = STRAP_TABLE ? strap_code : (pick ? set_two : set_one);

  logic [15:0] step, interval;
  assign interval = (state == buck_pkg::ST_SOFT) ? 16'(SS_CYC / 128) : ramp_interval(ramp);

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ref_code_o <= 7'h00;
      step       <= 16'h0000;
    end else if (state != buck_pkg::ST_SOFT && next_state == buck_pkg::ST_SOFT) begin
      ref_code_o <= prebias_code_i;
      step       <= 16'h0000;
    end else if (!run) begin
      ref_code_o <= 7'h00;
      step       <= 16'h0000;
    end else if (step >= interval - 16'd1) begin
      step <= 16'h0000;
      if (ref_code_o < target) ref_code_o <= ref_code_o + 7'd1;
      else if (ref_code_o > target) ref_code_o <= ref_code_o - 7'd1;
    end else begin
      step <= step + 16'd1;
    end
  end

  // Voltage change flag; a new change outranks completion
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      target_d <= 7'h00;
      dynamic_voltage_change      <= 1'b0;
    end else begin
      target_d <= target;
      if (state == buck_pkg::ST_RUN && target != target_d) dynamic_voltage_change <= 1'b1;
      else if (!run || (ref_code_o == target && atg)) dynamic_voltage_change <= 1'b0;
    end
  end

  // ==================== Switch control
  always_ff @(posedge clk_i) begin
    if (!resetn_i || !run) cl <= 1'b0;
    else if (hsl) cl <= 1'b1;
    else if (lsl) cl <= 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      hs_on_o      <= 1'b0;
      ls_on_o      <= 1'b0;
      forced_pwm_o <= 1'b0;
      discharge_o  <= 1'b0;
    end else begin
      hs_on_o <= run & hsr & ~cl & ~hsl;
      ls_on_o <= run & (cl | hsl | ~hsr);
      // Only the explicit change bit lets a target change force PWM
      forced_pwm_o <= fpwm | (fchg & dynamic_voltage_change);
      discharge_o  <= disch & ((state == buck_pkg::ST_OFF && ever) ||
                               state == buck_pkg::ST_IDLE || state == buck_pkg::ST_THERM ||
                               state == buck_pkg::ST_INPUT_UNDERVOLTAGE_LOCKOUT);
    end
  end

  // ==================== Power good
  logic [19:0] pg_tmr;
  always_ff @(posedge clk_i) begin
    if (!resetn_i || !run || !a96) pg_tmr <= '0;
    else if (pg_tmr != 20'(PG_CYC)) pg_tmr <= pg_tmr + 20'd1;
  end

  assign pg_low = ever & (!en || state == buck_pkg::ST_THERM || !run || !a96 ||
                          dynamic_voltage_change || pg_tmr != 20'(PG_CYC));

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      power_good_output_o    <= 1'b0;
      power_good_output_oe_o <= 1'b0;
    end else begin
      power_good_output_o    <= 1'b0;
      power_good_output_oe_o <= pg_low;
    end
  end

  // ==================== Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  en_low_off_a: assert property (!en |=> state == buck_pkg::ST_OFF)
    else $error("EN low did not force off");
  delay_hold_a: assert property (state == buck_pkg::ST_DELAY && timer < 20'(ED_CYC - 1) && en && !input_undervoltage_lockout
    |=> state == buck_pkg::ST_DELAY)
    else $error("Enable delay ended early");
  early_write_a: assert property (wr_pend && !live && en |=> $stable(set_one) && $stable(swen))
    else $error("Write taken before bus live");
  sw_start_a: assert property (state == buck_pkg::ST_IDLE && swen && en && !input_undervoltage_lockout
    |=> state == buck_pkg::ST_SOFT)
    else $error("Software enable did not soft-start");
  idle_quiet_a: assert property (state == buck_pkg::ST_IDLE |=> !hs_on_o)
    else $error("Switching while disabled");
  prebias_start_a: assert property (state != buck_pkg::ST_SOFT && next_state == buck_pkg::ST_SOFT
    |=> ref_code_o == $past(prebias_code_i))
    else $error("Soft-start not from pre-bias");
  strap_pick_a: assert property (state == buck_pkg::ST_DELAY
    |=> strap_code == strap_lookup($past(vs1), $past(vs2)))
    else $error("Strap target wrong");
  hs_limit_a: assert property (hsl && run |=> !hs_on_o && ls_on_o)
    else $error("Current limit not honoured");
  dis_gate_a: assert property (!disch |=> !discharge_o)
    else $error("Discharge while bit clear");
  therm_stop_a: assert property (state == buck_pkg::ST_THERM |=> !hs_on_o && !ls_on_o)
    else $error("Switching in thermal shutdown");
  pg_first_a: assert property (!ever |=> !power_good_output_oe_o)
    else $error("Power-good pulled before first enable");
  pg_en_low_a: assert property (ever && !en |=> power_good_output_oe_o)
    else $error("Power-good released with EN low");
  input_undervoltage_lockout_stop_a: assert property (input_undervoltage_lockout && en && state != buck_pkg::ST_OFF
    |=> state == buck_pkg::ST_INPUT_UNDERVOLTAGE_LOCKOUT ##1 !hs_on_o)
    else $error("Undervoltage did not stop");
  pg_dvs_a: assert property (dynamic_voltage_change |=> power_good_output_oe_o)
    else $error("Power-good released during voltage change");
  no_force_a: assert property (!fpwm && !fchg |=> !forced_pwm_o)
    else $error("Forced PWM without control bit");
  pg_hold_a: assert property (ever && pg_tmr != 20'(PG_CYC) |=> power_good_output_oe_o)
    else $error("Power-good released before delay");
  therm_pfm_a: assert property (state == buck_pkg::ST_RUN && swen && en && !input_undervoltage_lockout && pfm && !fpwm
    |=> state == buck_pkg::ST_RUN)
    else $error("Thermal acted in light-load mode");

  start_c: cover property (state == buck_pkg::ST_SOFT ##1 state == buck_pkg::ST_RUN);
  dvs_c:   cover property ($rose(dynamic_voltage_change) ##[1:1000] $fell(dynamic_voltage_change));
  therm_c: cover property (state == buck_pkg::ST_THERM ##1 state == buck_pkg::ST_SOFT);
  pg_c:    cover property ($fell(power_good_output_oe_o));
  fchg_c:  cover property (forced_pwm_o && !fpwm);

endmodule : buck_regulator_sequencer

// >>> core/buck_map.svh
`ifndef BUCK_MAP_SVH
`define BUCK_MAP_SVH

// ==================== Register offsets
`define OFS_SET_ONE 8'h00
`define OFS_SET_TWO 8'h04
`define OFS_CTL     8'h08
`define OFS_STATUS  8'h0C
// ==================== Control fields
`define CTL_RAMP_LSB 0
`define CTL_DIS      3
`define CTL_FPWM     4
`define CTL_SWEN     5
`define CTL_FCHG     6
// ==================== Reset values
`define SET_ONE_RST 7'h10
`define SET_TWO_RST 7'h10
`define RAMP_RST    2'h0
`define SWEN_RST    1'b1
`define DIS_RST     1'b1
// ==================== Strap targets, 12.5 mV codes
`define STRAP_00 7'h10
`define STRAP_10 7'h18
`define STRAP_01 7'h20
`define STRAP_11 7'h30
// ==================== Timing
`define CLK_MHZ       200
`define EN_DELAY_US   500
`define EN_DELAY_CYC  (`EN_DELAY_US * `CLK_MHZ)
`define SOFT_START_MS 0.12
`define SOFT_START_CYC (int'(`SOFT_START_MS * 1000.0 * `CLK_MHZ))
`define PG_DELAY_US   50
`define PG_DELAY_CYC  (`PG_DELAY_US * `CLK_MHZ)
`define RAMP_STEP0 16'h0190
`define RAMP_STEP1 16'h00C8
`define RAMP_STEP2 16'h0064
`define RAMP_STEP3 16'h0032
// ==================== Pin vector positions
`define P_EN   0
`define P_PICK 1
`define P_VS1  2
`define P_VS2  3
`define P_INPUT_UNDERVOLTAGE_LOCKOUT 4
`define P_TSD  5
`define P_HSL  6
`define P_LSL  7
`define P_A96  8
`define P_ATG  9
`define P_PFM  10
`define P_HSR  11
`define NPINS  12
`endif

// >>> core/buck_pkg.sv
package buck_pkg;
  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_DELAY = 3'b001,
    ST_SOFT  = 3'b010,
    ST_RUN   = 3'b011,
    ST_IDLE  = 3'b100,
    ST_THERM = 3'b101,
    ST_INPUT_UNDERVOLTAGE_LOCKOUT  = 3'b110
  } seq_state_t;
endpackage : buck_pkg

// >>> verif/buck_far_side.sv
`timescale 1ns/1ps
module buck_far_side #(
  parameter logic [6:0] PRE = 7'h08
) (
  input  wire logic       clk_i,
  input  wire logic       slow_i,
  input  wire logic [6:0] ref_code_i,
  input  wire logic [6:0] tgt_i,
  output logic            at_96_o,
  output logic            at_target_o,
  output logic      [6:0] prebias_code_o
);
  logic [1:0] a96 = 2'b00;
  logic [1:0] atg = 2'b00;
  // ==================== Output comparators, optional extra lag
  always_ff @(posedge clk_i) begin
    a96 <= {a96[0], (int'(ref_code_i) * 100 >= int'(tgt_i) * 96) && (ref_code_i != 7'h00)};
    atg <= {atg[0], ref_code_i == tgt_i};
  end
  assign at_96_o        = slow_i ? a96[1] : a96[0];
  assign at_target_o    = slow_i ? atg[1] : atg[0];
  assign prebias_code_o = PRE;
endmodule : buck_far_side

// >>> verif/testbench.sv
`timescale 1ns/1ps
`include "buck_map.svh"
module testbench;
  localparam int          ED      = 40;
  localparam int          SS      = 256;
  localparam int          PG      = 20;
  localparam logic [6:0]  PRE     = 7'h08;
  localparam logic [31:0] CTL_RST = 32'h0000_0028;
  logic        clk_i    = 1'b0;
  logic        resetn_i = 1'b0;
  logic        hsel     = 1'b0;
  logic        hwrite   = 1'b0;
  logic [1:0]  htrans   = 2'b00;
  logic [31:0] haddr    = 32'h0000_0000;
  logic [31:0] hwdata   = 32'h0000_0000;
  logic        en = 1'b0, pick = 1'b0, input_undervoltage_lockout = 1'b0, therm = 1'b0, hsl = 1'b0;
  logic        lsl = 1'b0, pfm = 1'b0, hsr = 1'b0, slow = 1'b0, vs_a = 1'b0, vs_b = 1'b0;
  logic [6:0]  tgt      = 7'h10;
  logic [31:0] rd;
  logic [31:0] hrdata;
  logic        hrdy, hresp, hs_on, ls_on, dis, fpwm, pg, pg_oe, a96, atg;
  logic [6:0]  refc, pre;
  int          err_count = 0;
  int          tests_run = 0;
  int          hi96      = 0;
  time         t0;

  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) hi96 <= a96 ? hi96 + 1 : 0;

  buck_regulator_sequencer #(.ED_CYC(ED), .SS_CYC(SS), .PG_CYC(PG)) u_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .chip_enable_i(en), .voltage_select_pin_i(pick),
    .voltage_select_first_i(vs_a), .voltage_select_second_i(vs_b), .input_undervoltage_lockout_i(input_undervoltage_lockout), .thermal_i(therm),
    .hs_limit_i(hsl), .ls_limit_i(lsl), .at_96_i(a96), .at_target_i(atg), .light_load_save_mode_i(pfm),
    .hs_request_i(hsr), .prebias_code_i(pre), .hs_on_o(hs_on), .ls_on_o(ls_on), .discharge_o(dis),
    .forced_pwm_o(fpwm), .ref_code_o(refc), .power_good_output_o(pg), .power_good_output_oe_o(pg_oe));

  buck_far_side #(.PRE(PRE)) u_far (
    .clk_i(clk_i), .slow_i(slow), .ref_code_i(refc), .tgt_i(tgt), .at_96_o(a96), .at_target_o(atg),
    .prebias_code_o(pre));

  // ==================== Reporting
  task results;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task tmo;
    err_count++;
    results();
  endtask : tmo
  task done(input string s);
    $display("test %s done", s);
  endtask : done
  function int since;
    return int'(($time - t0) / 5);
  endfunction : since
  // ==================== Bus and waits
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  task rdy;
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_i);
      if (hrdy === 1'b1) break;
    end
    if (i == 50) tmo();
  endtask : rdy
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    rdy();
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask : ahb
  task wait_st(input logic [2:0] s);
    int i;
    for (i = 0; i < 400; i++) begin
      ahb(1'b0, `OFS_STATUS, 32'h0000_0000);
      if (rd[5:3] === s) break;
    end
    if (i == 400) tmo();
  endtask : wait_st
  task wait_ref(input logic [6:0] v, input logic eq);
    int i;
    for (i = 0; i < 2000; i++) begin
      @(posedge clk_i);
      if ((refc === v) == eq) break;
    end
    if (i == 2000) tmo();
  endtask : wait_ref
  task wait_pg(input logic v);
    int i;
    for (i = 0; i < 500; i++) begin
      @(posedge clk_i);
      if (pg_oe === v) break;
    end
    if (i == 500) tmo();
  endtask : wait_pg
  // ==================== Sequence
  initial begin
    cyc(3);
    resetn_i <= 1'b1;
    cyc(6);
    chk(pg_oe, 0);
    chk({pg, hresp}, 2'b00);
    ahb(1'b0, `OFS_CTL, 0); chk(rd, 0);
    done("reset");
    en <= 1'b1;
    t0 = $time;
    ahb(1'b1, `OFS_SET_ONE, 32'h0000_0033);
    ahb(1'b0, `OFS_SET_ONE, 0); chk(rd, 0);
    wait_ref(7'h00, 1'b0); chk(refc, PRE);
    chk(since() inside {[ED:ED+12]}, 1);
    t0 = $time;
    wait_ref(tgt, 1'b1); chk(since() <= SS, 1);
    wait_st(buck_pkg::ST_RUN);
    ahb(1'b0, `OFS_SET_ONE, 0); chk(rd, 32'h0000_0010);
    ahb(1'b0, `OFS_CTL, 0); chk(rd, CTL_RST);
    wait_pg(1'b0); chk(hi96 >= PG, 1);
    done("startup");
    ahb(1'b1, `OFS_CTL, 32'h0000_002B);
    ahb(1'b1, `OFS_SET_TWO, 32'h0000_0020);
    tgt  <= 7'h20;
    pick <= 1'b1;
    slow <= 1'b1;
    t0 = $time;
    wait_pg(1'b1); chk(since() <= 10, 1);
    chk(fpwm, 0);
    t0 = $time;
    wait_ref(7'h20, 1'b1); chk(since() inside {[740:820]}, 1);
    wait_pg(1'b0); chk(fpwm, 0);
    ahb(1'b0, `OFS_STATUS, 0); chk(rd, 32'h0004_0818);
    ahb(1'b1, `OFS_CTL, 32'h0000_003B); cyc(3); chk(fpwm, 1);
    ahb(1'b1, `OFS_CTL, 32'h0000_002B); cyc(3); chk(fpwm, 0);
    ahb(1'b1, `OFS_CTL, 32'h0000_006B);
    tgt  <= 7'h10;
    pick <= 1'b0;
    cyc(8); chk(fpwm, 1);
    wait_ref(7'h10, 1'b1); wait_pg(1'b0); chk(fpwm, 0);
    ahb(1'b1, `OFS_CTL, 32'h0000_002B);
    done("dvs");
    hsr <= 1'b1; cyc(8); chk({hs_on, ls_on}, 2'b10);
    hsl <= 1'b1; cyc(8); chk({hs_on, ls_on}, 2'b01);
    hsl <= 1'b0; cyc(8); chk({hs_on, ls_on}, 2'b01);
    lsl <= 1'b1; cyc(8); chk({hs_on, ls_on}, 2'b10);
    lsl <= 1'b0;
    done("limit");
    pfm   <= 1'b1;
    therm <= 1'b1;
    cyc(12);
    ahb(1'b0, `OFS_STATUS, 0); chk(rd[5:3], buck_pkg::ST_RUN);
    pfm <= 1'b0;
    wait_st(buck_pkg::ST_THERM);
    cyc(2);
    chk({hs_on, ls_on, dis, pg_oe}, 4'b0011);
    ahb(1'b0, `OFS_SET_TWO, 0); chk(rd, 32'h0000_0020);
    therm <= 1'b0;
    wait_st(buck_pkg::ST_SOFT);
    wait_st(buck_pkg::ST_RUN);
    done("thermal");
    ahb(1'b1, `OFS_CTL, 32'h0000_000B); cyc(3);
    chk({hs_on, ls_on, dis}, 3'b001);
    ahb(1'b0, `OFS_CTL, 0); chk(rd, 32'h0000_000B);
    ahb(1'b1, `OFS_CTL, 32'h0000_002B);
    t0 = $time;
    wait_ref(7'h00, 1'b0); chk(since() <= 8, 1);
    wait_st(buck_pkg::ST_RUN);
    done("swen");
    ahb(1'b1, `OFS_CTL, 32'h0000_0023);
    ahb(1'b1, `OFS_CTL, 32'h0000_0003); cyc(3); chk(dis, 0);
    en  <= 1'b0;
    tgt <= 7'h10;
    cyc(8); chk({hs_on, ls_on, dis, pg_oe}, 4'b0001);
    en <= 1'b1;
    wait_st(buck_pkg::ST_RUN);
    ahb(1'b0, `OFS_SET_TWO, 0); chk(rd, 32'h0000_0010);
    ahb(1'b0, `OFS_CTL, 0); chk(rd, CTL_RST);
    en <= 1'b0;
    cyc(8); chk(dis, 1);
    done("discharge");
    en <= 1'b1;
    wait_st(buck_pkg::ST_RUN);
    input_undervoltage_lockout <= 1'b1;
    cyc(8); chk({hs_on, ls_on, dis}, 3'b001);
    ahb(1'b0, `OFS_STATUS, 0); chk(rd, 0);
    vs_a <= 1'b1;
    input_undervoltage_lockout <= 1'b0;
    wait_st(buck_pkg::ST_RUN);
    chk(u_dut.strap_code, `STRAP_10);
    done("input_undervoltage_lockout");
    results();
  end
endmodule : testbench
